//--- logic/kdrh_pkg.sv
// constants and types of the key data read handshake block
package kdrh_pkg;
    // ==========================================================
    // geometry
    localparam int KEY_BITS = 30;
    localparam int SCAN_LINES = 6;
    localparam int KEY_INS = 5;
    localparam int SEG_NUM = 60;
    localparam int COM_NUM = 10;
    localparam int GPO_NUM = 4;
    localparam int KSC_NUM = 6;
    // ==========================================================
    // oscillator and scan timing, in oscillator periods (T)
    localparam int OSC_DIV_DEF = 4;
    localparam logic [8:0] PASS_T = 9'h190;
    localparam logic [10:0] AGREE_T = 11'h0320;
    localparam logic [10:0] RETRY_T = 11'h0640;
    localparam int LINE_BITS = 6;
    // ==========================================================
    // serial link
    localparam logic [7:0] KEY_ADDR = 8'h43;
    // ==========================================================
    // register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DISP_OFS = 8'h04;
    localparam logic [7:0] STS_OFS = 8'h08;
    localparam logic [7:0] MASK_OFS = 8'h0C;
    localparam logic [7:0] KEY_OFS = 8'h10;
    // ==========================================================
    // fields and reset values
    localparam int CTRL_KSC_LSB = 0;
    localparam int CTRL_GPO_LSB = 6;
    localparam int CTRL_SLEEP_BIT = 10;
    localparam int CTRL_W = 11;
    localparam int STS_READY_BIT = 0;
    localparam int STS_READ_BIT = 1;
    localparam int STS_W = 2;
    localparam int STS_LOADED_BIT = 8;
    localparam int STS_VALID_BIT = 9;
    localparam logic [10:0] CTRL_RST = 11'h000;
    localparam logic [1:0] STS_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    // ==========================================================
    // key scan states, gray along idle -> scan -> hold
    typedef enum logic [1:0] {
        SC_IDLE = 2'b00,
        SC_SCAN = 2'b01,
        SC_HOLD = 2'b11
    } kdrh_scan_type;
endpackage : kdrh_pkg

//--- logic/kdrh_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module kdrh_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] lvl_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] lvl_r;
    logic [W-1:0] lvl_nxt;
    // a change counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            assign lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
        end
    endgenerate
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            lvl_r <= '0;
        end else begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end
    assign lvl_o = lvl_r;
    assign rise_o = lvl_nxt & ~lvl_r;
    assign fall_o = ~lvl_nxt & lvl_r;
endmodule : kdrh_sync
`default_nettype wire

//--- logic/kdrh_core.sv
// key data read handshake: key scan, serial key read, apb registers
//
// Contract
// R1: during reset segment, common, scan and general outputs sit low.
// R2: data out stays released until key scan control bits are written.
// R3: controller sends display data in four separate transfers.
// R4: controller should finish the four display transfers within 30 ms.
// R5: two agreeing scans end the scan after 800 periods, then report.
// R6: disagreeing scans rescan, so reporting comes after 1600 periods.
// R7: key read starts with address 43h, then key data shifts out.
// R8: data out low while enable is low means key data waits.
// R9: controller polling period exceeds rescan, address and read times.
// R10: controller ignores key data read while data out was high.
// R11: after a key read controller waits longer than the rescan time.
// R12: after reset scanning stays off and key data zero until control.
// R13: scan durations count internal oscillator periods.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module kdrh_core #(
    parameter int OSC_DIV = kdrh_pkg::OSC_DIV_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o,
    input wire logic ce_i,
    input wire logic cl_i,
    input wire logic di_i,
    output logic do_o,
    output logic do_oe_o,
    input wire logic [kdrh_pkg::KEY_INS-1:0] key_in_i,
    output logic [kdrh_pkg::KSC_NUM-1:0] key_scan_outputs_o,
    output logic [kdrh_pkg::GPO_NUM-1:0] general_outputs_o,
    input wire logic [kdrh_pkg::SEG_NUM-1:0] seg_wave_i,
    input wire logic [kdrh_pkg::COM_NUM-1:0] com_wave_i,
    output logic [kdrh_pkg::SEG_NUM-1:0] segment_outputs_o,
    output logic [kdrh_pkg::COM_NUM-1:0] common_outputs_o
);
    import kdrh_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic [7:0] pin_lvl;
    logic [7:0] pin_rise;
    logic [7:0] pin_fall;
    kdrh_sync #(.W(8)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({key_in_i, di_i, cl_i, ce_i}),
        .lvl_o(pin_lvl),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );
    wire ce_f = pin_lvl[0];
    wire ce_rise = pin_rise[0];
    wire ce_fall = pin_fall[0];
    wire cl_rise = pin_rise[1];
    wire cl_fall = pin_fall[1];
    wire di_f = pin_lvl[2];
    wire [KEY_INS-1:0] ki_f = pin_lvl[7:3];

    // ==========================================================
    // oscillator period tick
    logic [7:0] osc_cnt_r;
    wire osc_tick = (osc_cnt_r == 8'(OSC_DIV - 1));
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_cnt_r <= '0;
        end else begin
            osc_cnt_r <= osc_tick ? 8'h00 : osc_cnt_r + 8'h01; // [R13]
        end
    end

    // ==========================================================
    // apb decode
    logic [CTRL_W-1:0] ctrl_r;
    logic ctrl_loaded_r;
    logic disp_on_r;
    logic [STS_W-1:0] sts_r;
    logic [STS_W-1:0] mask_r;
    logic [31:0] prdata_r;
    logic [KEY_BITS-1:0] key_data_r;
    kdrh_scan_type state_r;
    wire setup = psel_i & ~penable_i;
    wire wr = psel_i & penable_i & pwrite_i;
    wire hit_ctrl = (paddr_i == CTRL_OFS);
    wire hit_disp = (paddr_i == DISP_OFS);
    wire hit_sts = (paddr_i == STS_OFS);
    wire hit_mask = (paddr_i == MASK_OFS);
    wire hit_key = (paddr_i == KEY_OFS);
    wire mapped = hit_ctrl | hit_disp | hit_sts | hit_mask | hit_key;
    wire key_valid = (state_r == SC_HOLD);
    wire [KSC_NUM-1:0] ksc = ctrl_r[CTRL_KSC_LSB +: KSC_NUM];
    wire [31:0] sts_word = {22'h00_0000, key_valid, ctrl_loaded_r,
                            6'h00, sts_r};
    wire [31:0] rd_mux =
        hit_ctrl ? {21'h00_0000, ctrl_r} :
        hit_disp ? {31'h0000_0000, disp_on_r} :
        hit_sts ? sts_word :
        hit_mask ? {30'h0000_0000, mask_r} :
        hit_key ? {2'h0, key_data_r} : 32'h0000_0000;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;
    assign prdata_o = prdata_r;

    // ==========================================================
    // key scan engine
    logic [8:0] pass_cnt_r;
    logic [1:0] pass_num_r;
    logic [10:0] tot_cnt_r;
    logic [KEY_BITS-1:0] prev_r;
    logic [KEY_BITS-1:0] cur_r;
    logic [KEY_BITS-1:0] cur_nxt;
    logic [KSC_NUM-1:0] kso_r;
    logic read_done;
    wire [2:0] line = pass_cnt_r[8:LINE_BITS];
    wire slot_end = osc_tick & (&pass_cnt_r[LINE_BITS-1:0])
                    & (line < 3'(SCAN_LINES));
    wire pass_end = osc_tick & (pass_cnt_r == PASS_T - 9'h001);
    wire agree = (prev_r == cur_r);
    wire scanning = (state_r == SC_SCAN);
    wire scan_start = (state_r == SC_IDLE) & ctrl_loaded_r & (|ki_f)
                      & (|ksc); // [R12]
    wire scan_done = scanning & pass_end & pass_num_r[0]
                     & (agree | (pass_num_r == 2'h3)); // [R5] [R6]
    wire [KSC_NUM-1:0] line_hot = KSC_NUM'(1) << line;
    wire [KSC_NUM-1:0] kso_nxt =
        scanning ? (line_hot & ksc) :
        (state_r == SC_IDLE && ctrl_loaded_r) ? ksc : '0;

    genvar g;
    generate
        for (g = 0; g < SCAN_LINES; g++) begin : g_line
            assign cur_nxt[g*KEY_INS +: KEY_INS] =
                (slot_end && line == 3'(g)) ? ki_f
                                            : cur_r[g*KEY_INS +: KEY_INS];
        end
    endgenerate

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= SC_IDLE;
            pass_cnt_r <= '0;
            pass_num_r <= '0;
            tot_cnt_r <= '0;
            prev_r <= '0;
            cur_r <= '0;
            key_data_r <= '0; // [R12]
            kso_r <= '0; // [R1]
        end else begin
            kso_r <= kso_nxt;
            case (state_r)
                SC_IDLE: begin
                    if (scan_start) begin
                        state_r <= SC_SCAN;
                        pass_cnt_r <= '0;
                        pass_num_r <= '0;
                        tot_cnt_r <= '0;
                        cur_r <= '0;
                    end
                end
                SC_SCAN: begin
                    cur_r <= cur_nxt;
                    if (osc_tick) begin
                        tot_cnt_r <= tot_cnt_r + 11'h001; // [R13]
                        pass_cnt_r <= pass_end ? 9'h000
                                               : pass_cnt_r + 9'h001;
                    end
                    if (scan_done) begin
                        state_r <= SC_HOLD;
                        key_data_r <= cur_r; // [R5] [R6]
                    end else if (pass_end) begin
                        pass_num_r <= pass_num_r + 2'h1; // [R6]
                        if (!pass_num_r[0]) begin
                            prev_r <= cur_r;
                        end
                    end
                end
                SC_HOLD: begin
                    if (read_done) begin
                        state_r <= SC_IDLE;
                    end
                end
                default: begin
                    state_r <= SC_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // serial key read over the three-wire link
    logic [7:0] addr_r;
    logic read_act_r;
    logic [KEY_BITS:0] shift_r;
    logic do_oe_r;
    wire addr_ok = (addr_r == KEY_ADDR);
    wire sleep_ack = ctrl_r[CTRL_SLEEP_BIT];
    assign read_done = read_act_r & ce_fall;
    // released before control load; pulled low for waiting key data
    wire do_oe_nxt = ~ctrl_loaded_r ? 1'b0 : // [R2]
                     read_act_r ? ~shift_r[0] : // [R7]
                     (~ce_f & key_valid); // [R8]

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_r <= '0;
            read_act_r <= 1'b0;
            shift_r <= '0;
            do_oe_r <= 1'b0;
        end else begin
            do_oe_r <= do_oe_nxt;
            if (!ce_f && cl_rise) begin
                addr_r <= {di_f, addr_r[7:1]};
            end
            if (ce_rise) begin
                read_act_r <= ctrl_loaded_r & addr_ok; // [R7] [R2]
                shift_r <= {sleep_ack, key_data_r};
            end else if (read_done) begin
                read_act_r <= 1'b0;
            end else if (read_act_r && cl_fall) begin
                shift_r <= {1'b0, shift_r[KEY_BITS:1]};
            end
        end
    end
    assign do_o = 1'b0;
    assign do_oe_o = do_oe_r;

    // ==========================================================
    // registers, interrupt and output stages
    wire [STS_W-1:0] sts_ev = {read_done, scan_done};
    wire [STS_W-1:0] sts_clr = (wr && hit_sts) ? pwdata_i[STS_W-1:0] : '0;
    logic [GPO_NUM-1:0] gpo_r;
    logic [SEG_NUM-1:0] seg_r;
    logic [COM_NUM-1:0] com_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RST;
            ctrl_loaded_r <= 1'b0;
            disp_on_r <= 1'b0;
            sts_r <= STS_RST;
            mask_r <= MASK_RST;
            prdata_r <= '0;
            gpo_r <= '0;
            seg_r <= '0;
            com_r <= '0;
        end else begin
            if (setup) begin
                prdata_r <= rd_mux;
            end
            if (wr && hit_ctrl) begin
                ctrl_r <= pwdata_i[CTRL_W-1:0];
                ctrl_loaded_r <= 1'b1; // [R12]
            end
            if (wr && hit_disp) begin
                disp_on_r <= pwdata_i[0];
            end
            if (wr && hit_mask) begin
                mask_r <= pwdata_i[STS_W-1:0];
            end
            sts_r <= (sts_r & ~sts_clr) | sts_ev;
            gpo_r <= ctrl_loaded_r ? ctrl_r[CTRL_GPO_LSB +: GPO_NUM]
                                   : '0; // [R1]
            seg_r <= disp_on_r ? seg_wave_i : '0; // [R1]
            com_r <= disp_on_r ? com_wave_i : '0; // [R1]
        end
    end
    assign irq_o = |(sts_r & mask_r);
    assign key_scan_outputs_o = kso_r;
    assign general_outputs_o = gpo_r;
    assign segment_outputs_o = seg_r;
    assign common_outputs_o = com_r;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_read_end;
        read_act_r ##0 ce_fall;
    endsequence
    sequence seq_idle_wait;
        key_valid && ctrl_loaded_r && !ce_f && !read_act_r;
    endsequence

    a_outs_dark_off: assert property ( // [R1]
        !$past(disp_on_r) |-> (seg_r == '0 && com_r == '0))
        else $error("lcd outputs not low while display off");
    a_do_released_early: assert property ( // [R2]
        !ctrl_loaded_r |=> !do_oe_o)
        else $error("data out driven before control load");
    a_agree_800: assert property ( // [R5]
        scan_done && agree && pass_num_r == 2'h1
        |-> tot_cnt_r == AGREE_T - 11'h001)
        else $error("agreeing scan not 800 periods");
    a_retry_1600: assert property ( // [R6]
        scan_done && !(agree && pass_num_r == 2'h1)
        |-> tot_cnt_r == RETRY_T - 11'h001)
        else $error("repeated scan not 1600 periods");
    a_read_addr_match: assert property ( // [R7]
        $rose(read_act_r) |-> $past(addr_ok) && $past(ce_rise))
        else $error("key read without key address");
    a_read_clears_data: assert property ( // [R7]
        seq_read_end |=> !key_valid ##1 sts_r[STS_READ_BIT])
        else $error("key read end not handled");
    a_poll_low_level: assert property ( // [R8]
        seq_idle_wait |=> do_oe_o)
        else $error("waiting key data not shown low");
    a_keys_zero_early: assert property ( // [R12]
        !ctrl_loaded_r |-> key_data_r == '0 && state_r == SC_IDLE
                           && kso_r == '0)
        else $error("scan active before control load");
    a_osc_tick_spacing: assert property ( // [R13]
        osc_tick |=> !osc_tick [*3] ##1 osc_tick)
        else $error("oscillator period wrong");
endmodule : kdrh_core
`default_nettype wire

//--- tb/kdrh_ctrl_model.sv
// system controller model driving the three-wire serial key link
`timescale 1ns/1ps
`default_nettype none
module kdrh_ctrl_model (
    input wire logic do_line_i,
    output logic ce_o,
    output logic cl_o,
    output logic di_o
);
    import kdrh_pkg::*;
    // ==========================================================
    // serial clock runs only inside frames, 64 ns period
    localparam int HALF_NS = 32;
    initial begin
        ce_o = 1'b0;
        cl_o = 1'b0;
        di_o = 1'b0;
    end
    // ==========================================================
    // key read: ok tells whether data waited before the frame
    task automatic key_read(input logic [7:0] addr,
                            output logic [30:0] data, output logic ok);
        data = '0;
        ok = (do_line_i === 1'b0);
        ce_o = 1'b0;
        for (int i = 0; i < 8; i++) begin
            di_o = addr[i];
            #(HALF_NS) cl_o = 1'b1;
            #(HALF_NS) cl_o = 1'b0;
        end
        di_o = ~addr[7];
        #(HALF_NS) ce_o = 1'b1;
        for (int i = 0; i < 31; i++) begin
            #(HALF_NS) cl_o = 1'b1;
            #(HALF_NS) data[i] = do_line_i;
            cl_o = 1'b0;
        end
        #(HALF_NS) ce_o = 1'b0;
    endtask : key_read
endmodule : kdrh_ctrl_model
`default_nettype wire

//--- tb/key_data_read_handshake_tb_top.sv
// self-checking bench of the key data read handshake block
`timescale 1ns/1ps
`default_nettype none
module key_data_read_handshake_tb_top;
    import kdrh_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, q;
    logic ce_i, cl_i, di_i, do_o, do_oe_o, do_line, err, ok;
    logic [KEY_INS-1:0] key_in_i;
    logic [KSC_NUM-1:0] key_scan_outputs_o;
    logic [GPO_NUM-1:0] general_outputs_o;
    logic [SEG_NUM-1:0] seg_wave_i, segment_outputs_o;
    logic [COM_NUM-1:0] com_wave_i, common_outputs_o;
    logic [KEY_BITS-1:0] pressed;
    logic [30:0] kd;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    // ==========================================================
    // clock, open-drain line with pull-up, key matrix
    always #4 clk_i = ~clk_i;
    assign do_line = do_oe_o ? do_o : 1'b1;
    always_comb begin
        key_in_i = '0;
        for (int k = 0; k < KEY_BITS; k++) begin
            if (pressed[k] && key_scan_outputs_o[k / KEY_INS]) begin
                key_in_i[k % KEY_INS] = 1'b1;
            end
        end
    end
    kdrh_core #(.OSC_DIV(4)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .irq_o(irq_o), .ce_i(ce_i), .cl_i(cl_i),
        .di_i(di_i), .do_o(do_o), .do_oe_o(do_oe_o), .key_in_i(key_in_i),
        .key_scan_outputs_o(key_scan_outputs_o),
        .general_outputs_o(general_outputs_o), .seg_wave_i(seg_wave_i),
        .com_wave_i(com_wave_i), .segment_outputs_o(segment_outputs_o),
        .common_outputs_o(common_outputs_o)
    );
    kdrh_ctrl_model i_ctrl (
        .do_line_i(do_line), .ce_o(ce_i), .cl_o(cl_i), .di_o(di_i)
    );
    // ==========================================================
    // tasks
    task automatic check(input string nm, input logic [63:0] seen,
                         input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic apb_xfer(input logic w, input logic [7:0] a,
                            input logic [31:0] d);
        int t;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (pready_o !== 1'b1 && t < 50);
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb_xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb_xfer(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] exp);
        apb_xfer(1'b0, a, 32'h0);
        check(nm, q, exp);
    endtask : rd_chk
    // polls the data line with enable low at every clock, and waits
    // up to 8000 clocks, somewhat longer than the rescan, address and read times together
    task automatic wait_ready(input int chg_at);
        n = 0;
        while (do_line !== 1'b0 && n < 8000) begin
            @(posedge clk_i);
            n++;
            if (n == chg_at) pressed <= pressed | 30'h2000_0000;
        end
    endtask : wait_ready
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            finish_test();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        seg_wave_i = '1;
        com_wave_i = '1;
        pressed = 30'h0000_0008;
        repeat (5) @(posedge clk_i);
        check("seg_rst", segment_outputs_o, 64'h0);
        check("com_rst", common_outputs_o, 64'h0);
        check("ksc_rst", key_scan_outputs_o, 64'h0);
        check("gpo_rst", general_outputs_o, 64'h0);
        check("do_rst", do_line, 64'h1);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rd_chk("ctrl_rst", CTRL_OFS, 32'h0);
        rd_chk("sts_rst", STS_OFS, 32'h0);
        rd_chk("mask_rst", MASK_OFS, 32'h0);
        rd_chk("key_rst", KEY_OFS, 32'h0);
        check("no_scan", key_scan_outputs_o, 64'h0);
        i_ctrl.key_read(KEY_ADDR, kd, ok);
        check("early_read", {ok, kd}, 64'h7FFF_FFFF);
        apb_xfer(1'b0, 8'h20, 32'h0);
        check("bad_addr", {err, q}, 64'h1_0000_0000);
        pressed <= '0;
        wr(CTRL_OFS, 32'h0000_06BF);
        repeat (2) @(posedge clk_i);
        #1;
        check("gpo_set", general_outputs_o, 64'hA);
        rd_chk("sts_loaded", STS_OFS, 32'h0000_0100);
        wr(MASK_OFS, 32'h1);
        check("irq_idle", irq_o, 64'h0);
        pressed <= 30'h0002_0008;
        wait_ready(0);
        check("agree_time", n >= 3200 && n <= 3260, 64'h1);
        pressed <= '0;
        repeat (2) @(posedge clk_i);
        check("irq_set", irq_o, 64'h1);
        rd_chk("sts_done", STS_OFS, 32'h0000_0301);
        rd_chk("key_agree", KEY_OFS, 32'h0002_0008);
        wr(MASK_OFS, 32'h0);
        #1;
        check("irq_masked", irq_o, 64'h0);
        i_ctrl.key_read(8'h42, kd, ok);
        check("wrong_addr", {ok, kd}, 64'hFFFF_FFFF);
        repeat (10) @(posedge clk_i);
        check("do_waits", do_line, 64'h0);
        i_ctrl.key_read(KEY_ADDR, kd, ok);
        check("key_data", {ok, kd}, 64'hC002_0008);
        repeat (10) @(posedge clk_i);
        check("do_release", do_line, 64'h1);
        rd_chk("sts_read", STS_OFS, 32'h0000_0103);
        wr(STS_OFS, 32'h3);
        wr(MASK_OFS, 32'h3);
        rd_chk("sts_clear", STS_OFS, 32'h0000_0100);
        check("irq_clear", irq_o, 64'h0);
        pressed <= 30'h0000_0001;
        wait_ready(1900);
        check("retry_time", n >= 6400 && n <= 6460, 64'h1);
        pressed <= '0;
        rd_chk("key_retry", KEY_OFS, 32'h2000_0001);
        i_ctrl.key_read(KEY_ADDR, kd, ok);
        check("retry_data", {ok, kd}, 64'hE000_0001);
        // display data goes over in four transfers, well inside 30 ms
        for (int p = 0; p < 4; p++) begin
            wr(DISP_OFS, 32'h1);
        end
        repeat (3) @(posedge clk_i);
        check("seg_on", segment_outputs_o, {4'h0, seg_wave_i});
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        check("seg_rst2", segment_outputs_o, 64'h0);
        check("gpo_rst2", general_outputs_o, 64'h0);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rd_chk("key_rst2", KEY_OFS, 32'h0);
        finish_test();
    end
endmodule : key_data_read_handshake_tb_top
`default_nettype wire
